/* File: include/mode_rate_pkg.sv */
// package: register map, mode codes, timing and carrier types for mode and rate control
package mode_rate_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_MODE = 6'h10;
  localparam logic [5:0] IDX_RATE = 6'h11;
  localparam logic [5:0] IDX_WINDOW = 6'h29;
  localparam logic [5:0] IDX_STATUS = 6'h30;

  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] BURST_FOREVER = 8'hFF;

  // ----------------------------------------------------------------
  // mode select codes and field positions
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_WATCH = 3'h2;
  localparam logic [2:0] MODE_RSVD_A = 3'h3;
  localparam logic [2:0] MODE_RSVD_B = 3'h4;
  localparam logic [2:0] MODE_CONT = 3'h5;
  localparam logic [2:0] MODE_COMBINED = 3'h6;
  localparam logic [2:0] MODE_BURST = 3'h7;
  localparam int BURST_START_BIT = 7;
  localparam int AXIS_LO = 4;
  localparam int RATE_LO = 0;
  localparam int PTR_LO = 4;
  localparam logic [2:0] PTR_OFF = 3'h0;
  localparam logic [2:0] PTR_WAKE_FINE = 3'h2;
  localparam logic [2:0] PTR_WATCH_FINE = 3'h3;

  // ----------------------------------------------------------------
  // heartbeat timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int HB_PERIOD_NS = 1000;
  localparam int HB_CYCLES = (HB_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] MODE_APPLY_TICKS = 2'h2;
  localparam int MODE_MAX_TICKS = 3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] activeMode;
    logic watchEn;
    logic samplingEn;
    logic fifoEn;
    logic [2:0] axisEn;
    logic burstRun;
    logic [3:0] rateCode;
  } ctrl_s;

  typedef struct packed {
    logic [3:0] watchCoef;
    logic [3:0] wakeCoef;
    logic [4:0] wakeFine;
    logic [4:0] watchFine;
    logic [15:0] wakeCount;
    logic [15:0] watchCount;
  } shadow_s;

  typedef struct packed {
    logic [1:0] actSync;
    logic [1:0] smpSync;
    logic actDly;
    logic smpDly;
    logic ack;
    logic [7:0] rdata;
    logic [15:0] hbCnt;
    logic [1:0] hbTicks;
    logic pending;
    logic [2:0] modeReq;
    logic [2:0] modeAct;
    logic [2:0] axisDis;
    logic [7:0] rate;
    logic [7:0] burstTotal;
    logic [7:0] burstDone;
    logic [6:0][7:0] shadow;
    ctrl_s ctrl;
  } state_s;

endpackage : mode_rate_pkg

/* File: rtl/mode_and_rate_control.sv */
// module: accelerometer mode, axis, counted burst and wake rate control behind a wishbone slave
//
// Contract
// - mode codes: sleep, standby, watch, continuous
// - watch mode no sampling; activity enters continuous
// - mode change lands within three heartbeats
// - hardware may rewrite the mode field
// - code 110 runs watch, sampling, fifo
// - code 111 counted burst, then low power
// - bits 4..6 disable X, Y, Z
// - bit 7 starts one-shot counted burst
// - burst count 255 samples forever
// - burst count comes from window register
// - burst done returns to standby
// - rate low nibble selects output rate
// - rate codes from 0x05 rise in rate
// - rate bits 6..4 point the window
// - pointer zero leaves shadows unreached
// - seven shadows: coefs, fine picks, counts
`timescale 1ns/10ps
module mode_and_rate_control #(
  parameter int unsigned HB_CYCLES = mode_rate_pkg::HB_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic activityPin,
  input wire logic sampleDonePin,
  output mode_rate_pkg::ctrl_s ctrlOut,
  output mode_rate_pkg::shadow_s shadowOut
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mode_rate_pkg::state_s st_r;
  mode_rate_pkg::state_s st_nxt;

  localparam logic [15:0] HB_LAST = 16'(HB_CYCLES - 1);

  logic busAcc;
  logic busWr;
  logic [5:0] idx;
  logic actRise;
  logic smpRise;
  logic hbTick;
  logic [2:0] ptr;
  logic [7:0] doneInc;
  logic [7:0] burstGoal;
  logic [2:0] wrMode;
  logic inStandby;

  assign idx = wb_adr_i[7:2];
  assign busAcc = wb_cyc_i & wb_stb_i & ~st_r.ack;
  assign busWr = busAcc & wb_we_i & wb_sel_i[0];
  assign actRise = st_r.actSync[1] & ~st_r.actDly;
  assign smpRise = st_r.smpSync[1] & ~st_r.smpDly;
  assign hbTick = (st_r.hbCnt == HB_LAST);
  assign ptr = st_r.rate[mode_rate_pkg::PTR_LO+2:mode_rate_pkg::PTR_LO];
  assign doneInc = st_r.burstDone + 8'h01;
  // a count of zero is taken as one sample
  assign burstGoal = (st_r.burstTotal == 8'h00) ? 8'h01 : st_r.burstTotal;
  assign wrMode = wb_dat_i[2:0];
  assign inStandby = (st_r.modeAct == mode_rate_pkg::MODE_STANDBY) & ~st_r.ctrl.burstRun;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.actSync = {st_r.actSync[0], activityPin};
    st_nxt.smpSync = {st_r.smpSync[0], sampleDonePin};
    st_nxt.actDly = st_r.actSync[1];
    st_nxt.smpDly = st_r.smpSync[1];
    st_nxt.ack = busAcc;
    st_nxt.hbCnt = hbTick ? 16'h0000 : st_r.hbCnt + 16'h0001;

    // deferred mode change waits for heartbeat edges
    if (st_r.pending && hbTick) begin
      if (st_r.hbTicks == mode_rate_pkg::MODE_APPLY_TICKS - 2'h1) begin
        st_nxt.modeAct = st_r.modeReq;
        st_nxt.pending = 1'b0;
        st_nxt.hbTicks = 2'h0;
        st_nxt.ctrl.burstRun = 1'b0;
      end else begin
        st_nxt.hbTicks = st_r.hbTicks + 2'h1;
      end
    end

    // watch mode leaves on its own when activity is seen
    if (st_r.modeAct == mode_rate_pkg::MODE_WATCH && actRise) begin
      st_nxt.modeAct = mode_rate_pkg::MODE_CONT;
    end

    // counted burst: 255 never ends, otherwise stop at the goal
    if (st_r.ctrl.burstRun && smpRise && st_r.burstTotal != mode_rate_pkg::BURST_FOREVER) begin
      st_nxt.burstDone = doneInc;
      if (doneInc >= burstGoal) begin
        st_nxt.ctrl.burstRun = 1'b0;
        st_nxt.modeAct = mode_rate_pkg::MODE_STANDBY;
      end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (busWr) begin
      unique case (idx)
        mode_rate_pkg::IDX_MODE: begin
          st_nxt.axisDis = wb_dat_i[mode_rate_pkg::AXIS_LO+2:mode_rate_pkg::AXIS_LO];
          // a burst asked for outside standby is ignored; of the rest of the write only the axis disables stand, the mode field is dropped
          if (wb_dat_i[mode_rate_pkg::BURST_START_BIT] || wrMode == mode_rate_pkg::MODE_BURST) begin
            if (inStandby) begin
              st_nxt.ctrl.burstRun = 1'b1;
              st_nxt.burstDone = 8'h00;
              st_nxt.modeAct = mode_rate_pkg::MODE_BURST;
              st_nxt.pending = 1'b0;
            end
          end else if (wrMode != mode_rate_pkg::MODE_RSVD_A && wrMode != mode_rate_pkg::MODE_RSVD_B) begin
            st_nxt.modeReq = wrMode;
            st_nxt.pending = 1'b1;
            st_nxt.hbTicks = 2'h0;
          end
        end
        mode_rate_pkg::IDX_RATE: begin
          st_nxt.rate = {1'b0, wb_dat_i[6:0]};
        end
        mode_rate_pkg::IDX_WINDOW: begin
          if (ptr == mode_rate_pkg::PTR_OFF) begin
            st_nxt.burstTotal = wb_dat_i[7:0];
          end else if (ptr == mode_rate_pkg::PTR_WAKE_FINE || ptr == mode_rate_pkg::PTR_WATCH_FINE) begin
            st_nxt.shadow[ptr - 3'h1] = {3'h0, wb_dat_i[4:0]};
          end else begin
            st_nxt.shadow[ptr - 3'h1] = wb_dat_i[7:0];
          end
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // read data, unmapped reads answer zero
    // ----------------------------------------------------------------
    st_nxt.rdata = 8'h00;
    if (busAcc && !wb_we_i) begin
      unique case (idx)
        mode_rate_pkg::IDX_MODE: st_nxt.rdata = {st_r.ctrl.burstRun, st_r.axisDis, 1'b0, st_r.modeAct};
        mode_rate_pkg::IDX_RATE: st_nxt.rdata = st_r.rate;
        mode_rate_pkg::IDX_WINDOW: begin
          st_nxt.rdata = (ptr == mode_rate_pkg::PTR_OFF) ? st_r.burstTotal : st_r.shadow[ptr - 3'h1];
        end
        mode_rate_pkg::IDX_STATUS: st_nxt.rdata = {3'h0, st_r.ctrl.burstRun, st_r.pending, st_r.modeAct};
        default: st_nxt.rdata = 8'h00;
      endcase
    end

    // ----------------------------------------------------------------
    // block enables follow the mode about to be active
    // ----------------------------------------------------------------
    st_nxt.ctrl.activeMode = st_nxt.modeAct;
    st_nxt.ctrl.watchEn = (st_nxt.modeAct == mode_rate_pkg::MODE_WATCH) ||
                          (st_nxt.modeAct == mode_rate_pkg::MODE_COMBINED);
    st_nxt.ctrl.samplingEn = (st_nxt.modeAct == mode_rate_pkg::MODE_CONT) ||
                             (st_nxt.modeAct == mode_rate_pkg::MODE_COMBINED) ||
                             (st_nxt.modeAct == mode_rate_pkg::MODE_BURST);
    st_nxt.ctrl.fifoEn = st_nxt.ctrl.samplingEn;
    st_nxt.ctrl.axisEn = st_nxt.ctrl.samplingEn ? ~st_nxt.axisDis : 3'h0;
    // codes are passed on as written; meaning depends on the power mode kept elsewhere
    st_nxt.ctrl.rateCode = st_nxt.rate[mode_rate_pkg::RATE_LO+3:mode_rate_pkg::RATE_LO];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.modeAct <= mode_rate_pkg::MODE_SLEEP;
      st_r.modeReq <= mode_rate_pkg::MODE_SLEEP;
      st_r.rate <= mode_rate_pkg::RATE_RESET;
      st_r.burstTotal <= mode_rate_pkg::COUNT_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = {24'h00_0000, st_r.rdata};
  assign ctrlOut = st_r.ctrl;
  assign shadowOut.watchCoef = st_r.shadow[0][7:4];
  assign shadowOut.wakeCoef = st_r.shadow[0][3:0];
  assign shadowOut.wakeFine = st_r.shadow[1][4:0];
  assign shadowOut.watchFine = st_r.shadow[2][4:0];
  assign shadowOut.wakeCount = {st_r.shadow[4], st_r.shadow[3]};
  assign shadowOut.watchCount = {st_r.shadow[6], st_r.shadow[5]};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  localparam int HbCyc = int'(HB_CYCLES);
  // a queued mode lands by the second heartbeat tick; three periods leave margin
  localparam int ApplyMax = 3 * HbCyc + 2;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence seqModeWrite;
    busWr && idx == mode_rate_pkg::IDX_MODE && !wb_dat_i[mode_rate_pkg::BURST_START_BIT] &&
      wrMode == mode_rate_pkg::MODE_CONT;
  endsequence

  sequence seqBurstLast;
    st_r.ctrl.burstRun && smpRise && st_r.burstTotal != mode_rate_pkg::BURST_FOREVER &&
      doneInc >= burstGoal && !busWr;
  endsequence

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");

  // mode change latency stays within three heartbeat periods
  logic [15:0] pendAge;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pendAge <= 16'h0000;
    end else begin
      pendAge <= (st_r.pending && !(busWr && idx == mode_rate_pkg::IDX_MODE)) ? pendAge + 16'h0001 : 16'h0000;
    end
  end
  a_mode_latency: assert property (pendAge <= 16'(HbCyc * mode_rate_pkg::MODE_MAX_TICKS))
    else $error("mode change too slow");
  a_mode_lands: assert property (seqModeWrite ##1 (!busWr)[*1] |-> ##[0:ApplyMax]
    (st_r.modeAct == mode_rate_pkg::MODE_CONT || busWr))
    else $error("written mode never applied");

  a_watch_wakes: assert property (st_r.modeAct == mode_rate_pkg::MODE_WATCH && actRise && !busWr
    |=> st_r.modeAct == mode_rate_pkg::MODE_CONT)
    else $error("activity did not wake");
  a_watch_quiet: assert property (ctrlOut.activeMode == mode_rate_pkg::MODE_WATCH
    |-> !ctrlOut.samplingEn && !ctrlOut.fifoEn && ctrlOut.watchEn)
    else $error("watch mode sampling");
  a_combined_all: assert property (ctrlOut.activeMode == mode_rate_pkg::MODE_COMBINED
    |-> ctrlOut.samplingEn && ctrlOut.fifoEn && ctrlOut.watchEn)
    else $error("combined mode incomplete");
  a_axis_off: assert property (ctrlOut.samplingEn |-> ctrlOut.axisEn == ~st_r.axisDis)
    else $error("axis enable wrong");
  a_burst_done: assert property (seqBurstLast |=> st_r.modeAct == mode_rate_pkg::MODE_STANDBY &&
    !ctrlOut.burstRun)
    else $error("burst did not return to standby");
  a_burst_forever: assert property (st_r.ctrl.burstRun && st_r.burstTotal == mode_rate_pkg::BURST_FOREVER &&
    !busWr && !(st_r.pending && hbTick) |=> st_r.ctrl.burstRun)
    else $error("continuous burst stopped");
  a_burst_start: assert property (busWr && idx == mode_rate_pkg::IDX_MODE &&
    wb_dat_i[mode_rate_pkg::BURST_START_BIT] &&
    inStandby |=> ctrlOut.burstRun && ctrlOut.activeMode == mode_rate_pkg::MODE_BURST)
    else $error("burst did not start");
  a_burst_refuse: assert property (busWr && idx == mode_rate_pkg::IDX_MODE &&
    wb_dat_i[mode_rate_pkg::BURST_START_BIT] &&
    !inStandby && !st_r.ctrl.burstRun |=> !ctrlOut.burstRun)
    else $error("burst started outside standby");

endmodule : mode_and_rate_control

/* File: bench/tb.sv */
// testbench: register-level checks of mode, axis, counted burst and shadow rate control
`timescale 1ns/10ps
module tb;
  localparam int HB = 4;
  localparam int MODE_WAIT = 3 * HB + 2;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, activityPin = 1'b0, sampleDonePin = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0000_0000;
  logic [31:0] wbDatO, rd;
  logic wbAck;
  mode_rate_pkg::ctrl_s ctrlOut;
  mode_rate_pkg::shadow_s shadowOut;
  int num_errors = 0;
  int check_count = 0;

  mode_and_rate_control #(.HB_CYCLES(HB)) dut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .activityPin(activityPin), .sampleDonePin(sampleDonePin), .ctrlOut(ctrlOut), .shadowOut(shadowOut));

  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------
  // bench services
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one classic cycle; entered just after a rising edge, leaves one idle cycle behind
  task automatic access(input logic we, input logic [5:0] idx, input logic [7:0] dat, input logic [3:0] sel);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {idx, 2'b00};
    wbSel <= sel;
    wbDatI <= {24'h00_0000, dat};
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      complete_run();
    end
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge clk);
  endtask : access

  task automatic wr(input logic [5:0] idx, input logic [7:0] dat);
    access(1'b1, idx, dat, 4'h1);
  endtask : wr

  // a mode change must land within three heartbeats; a longer wait is a failure
  task automatic wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    while (ctrlOut.activeMode !== m && n < MODE_WAIT) begin
      @(posedge clk);
      n++;
    end
    chk("activeMode", {29'h0, m}, {29'h0, ctrlOut.activeMode});
  endtask : wait_mode

  task automatic pulse(input int count);
    repeat (count) begin
      sampleDonePin <= 1'b1;
      repeat (2) @(posedge clk);
      sampleDonePin <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask : pulse

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  logic [7:0] val [1:7];
  logic [3:0] flags [4] = '{4'h2, 4'h5, 4'h6, 4'h1};
  logic [2:0] expEn [4] = '{3'b100, 3'b011, 3'b111, 3'b000};
  logic [2:0] expAx [4] = '{3'b000, 3'b111, 3'b010, 3'b000};
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk("activeMode", 32'h0000_0001 >> 1, {29'h0, ctrlOut.activeMode});
    access(1'b0, mode_rate_pkg::IDX_RATE, 8'h00, 4'h1);
    chk("rate reset", 32'h0000_0000, rd);
    wr(mode_rate_pkg::IDX_RATE, 8'h78);
    access(1'b0, mode_rate_pkg::IDX_RATE, 8'h00, 4'h1);
    chk("rate readback", 32'h0000_0078, rd);
    chk("rateCode", 32'h0000_0008, {28'h0, ctrlOut.rateCode});
    for (int p = 1; p <= 7; p++) begin
      val[p] = 8'hE0 | 8'(p);
      wr(mode_rate_pkg::IDX_RATE, {1'b0, 3'(p), 4'h5});
      wr(mode_rate_pkg::IDX_WINDOW, val[p]);
      access(1'b0, mode_rate_pkg::IDX_WINDOW, 8'h00, 4'h1);
      chk("shadow readback", (p == 2 || p == 3) ? {24'h0, val[p] & 8'h1F} : {24'h0, val[p]}, rd);
    end
    chk("coefs", 32'h0000_00E1, {24'h0, shadowOut.watchCoef, shadowOut.wakeCoef});
    chk("fine picks", 32'h0000_0203, {19'h0, shadowOut.wakeFine, 3'h0, shadowOut.watchFine});
    chk("counts", 32'hE5E4_E7E6, {shadowOut.wakeCount, shadowOut.watchCount});
    wr(mode_rate_pkg::IDX_RATE, 8'h05);
    wr(mode_rate_pkg::IDX_WINDOW, 8'h03);
    chk("counts kept", 32'hE5E4_E7E6, {shadowOut.wakeCount, shadowOut.watchCount});
    access(1'b0, 6'h3F, 8'h00, 4'h1);
    chk("unmapped read", 32'h0000_0000, rd);
    access(1'b1, mode_rate_pkg::IDX_MODE, 8'h01, 4'h2);
    repeat (MODE_WAIT) @(posedge clk);
    chk("sel ignored", {29'h0, mode_rate_pkg::MODE_SLEEP}, {29'h0, ctrlOut.activeMode});
    for (int i = 0; i < 4; i++) begin
      // axis lanes only show while sampling, so the disable pattern rides on the combined mode
      wr(mode_rate_pkg::IDX_MODE, {1'b0, (i == 2) ? 3'b101 : 3'b000, 1'b0, flags[i][2:0]});
      wait_mode(flags[i][2:0]);
      chk("enables", {29'h0, expEn[i]}, {29'h0, ctrlOut.watchEn, ctrlOut.samplingEn, ctrlOut.fifoEn});
      chk("axisEn", {29'h0, expAx[i]}, {29'h0, ctrlOut.axisEn});
    end
    wr(mode_rate_pkg::IDX_MODE, 8'h23);
    repeat (MODE_WAIT) @(posedge clk);
    chk("reserved code", {29'h0, mode_rate_pkg::MODE_STANDBY}, {29'h0, ctrlOut.activeMode});
    access(1'b0, mode_rate_pkg::IDX_MODE, 8'h00, 4'h1);
    chk("mode readback", 32'h0000_0021, rd);
    wr(mode_rate_pkg::IDX_MODE, 8'h87);
    chk("burst start", 32'h0000_000F, {28'h0, ctrlOut.burstRun, ctrlOut.activeMode});
    access(1'b0, mode_rate_pkg::IDX_STATUS, 8'h00, 4'h1);
    chk("status", 32'h0000_0017, rd);
    pulse(2);
    chk("burst running", 32'h0000_0001, {31'h0, ctrlOut.burstRun});
    pulse(1);
    wait_mode(mode_rate_pkg::MODE_STANDBY);
    chk("burst ended", 32'h0000_0000, {31'h0, ctrlOut.burstRun});
    wr(mode_rate_pkg::IDX_WINDOW, 8'hFF);
    wr(mode_rate_pkg::IDX_MODE, 8'h87);
    pulse(6);
    chk("endless burst", 32'h0000_000F, {28'h0, ctrlOut.burstRun, ctrlOut.activeMode});
    wr(mode_rate_pkg::IDX_MODE, 8'h05);
    wait_mode(mode_rate_pkg::MODE_CONT);
    chk("burst stopped", 32'h0000_0000, {31'h0, ctrlOut.burstRun});
    wr(mode_rate_pkg::IDX_WINDOW, 8'h02);
    wr(mode_rate_pkg::IDX_MODE, 8'h80);
    repeat (4) @(posedge clk);
    chk("burst refused", 32'h0000_0005, {28'h0, ctrlOut.burstRun, ctrlOut.activeMode});
    wr(mode_rate_pkg::IDX_MODE, 8'h02);
    wait_mode(mode_rate_pkg::MODE_WATCH);
    activityPin <= 1'b1;
    wait_mode(mode_rate_pkg::MODE_CONT);
    activityPin <= 1'b0;
    chk("auto sampling", 32'h0000_0001, {31'h0, ctrlOut.samplingEn});
    complete_run();
  end
endmodule : tb
